// [hw/iaau_core.sv]
`timescale 1ns/1ps
`default_nettype none
module iaau_core
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);
    iaau_pkg::iaau_state_t r_reg;
    iaau_pkg::iaau_state_t r_next;
    iaau_pkg::iaau_kind_t  kind;

    logic [1:0]   f_op;
    logic [5:0]   f_oper;
    logic [8:0]   f_opf;
    logic         f_imm_sel;
    logic [63:0]  imm_ext;
    logic         is_carry;
    logic         is_cc;
    logic [63:0]  add_b;
    logic         add_cin;
    logic [63:0]  add_sum;
    logic [3:0]   icc;
    logic [3:0]   xcc;
    logic [1:0]   elem_shift;
    logic [63:0]  blk_addr;
    logic [127:0] joined;
    logic [63:0]  extract;
    logic         addr_phase;

    // instruction word split
    assign f_op      = r_reg.insn[iaau_pkg::OP_HI:iaau_pkg::OP_LO];
    assign f_oper    = r_reg.insn[iaau_pkg::OPER_HI:iaau_pkg::OPER_LO];
    assign f_opf     = r_reg.insn[iaau_pkg::OPF_HI:iaau_pkg::OPF_LO];
    assign f_imm_sel = r_reg.insn[iaau_pkg::IMM_SEL];
    assign imm_ext   = {{51{r_reg.insn[iaau_pkg::SIMM_HI]}},
                        r_reg.insn[iaau_pkg::SIMM_HI:0]};

    always_comb
    begin
        kind       = iaau_pkg::K_NONE;
        is_carry   = 1'b0;
        is_cc      = 1'b0;
        elem_shift = 2'h0;
        if (f_op == iaau_pkg::OP_ARITH)
        begin
            case (f_oper)
                iaau_pkg::OPER_ADD:   kind = iaau_pkg::K_ADD;
                iaau_pkg::OPER_ADDCC:
                begin
                    kind  = iaau_pkg::K_ADD;
                    is_cc = 1'b1;
                end
                iaau_pkg::OPER_ADDC:
                begin
                    kind     = iaau_pkg::K_ADD;
                    is_carry = 1'b1;
                end
                iaau_pkg::OPER_ADDCCC:
                begin
                    kind     = iaau_pkg::K_ADD;
                    is_carry = 1'b1;
                    is_cc    = 1'b1;
                end
                iaau_pkg::OPER_GRAPHICS:
                begin
                    case (f_opf)
                        iaau_pkg::OPF_ALIGN:    kind = iaau_pkg::K_ALIGN;
                        iaau_pkg::OPF_ALIGN_LE: kind = iaau_pkg::K_ALIGN_LE;
                        iaau_pkg::OPF_EXTRACT:  kind = iaau_pkg::K_EXTRACT;
                        iaau_pkg::OPF_BLK_BYTE: kind = iaau_pkg::K_ARRAY;
                        iaau_pkg::OPF_BLK_HALF:
                        begin
                            kind       = iaau_pkg::K_ARRAY;
                            elem_shift = 2'h1;
                        end
                        iaau_pkg::OPF_BLK_WORD:
                        begin
                            kind       = iaau_pkg::K_ARRAY;
                            elem_shift = 2'h2;
                        end
                        default:                kind = iaau_pkg::K_NONE;
                    endcase
                end
                default: kind = iaau_pkg::K_NONE;
            endcase
        end
    end

    // one adder serves add and align-address
    assign add_b   = (kind == iaau_pkg::K_ADD && f_imm_sel) ? imm_ext : r_reg.src2;
    assign add_cin = is_carry & r_reg.cc_flags[iaau_pkg::CC_C];

    iaau_adder u_adder
    (
        .a   (r_reg.src1),
        .b   (add_b),
        .cin (add_cin),
        .sum (add_sum),
        .icc (icc),
        .xcc (xcc)
    );

    iaau_blocked u_blocked
    (
        .src        (r_reg.src1),
        .size       (r_reg.src2[2:0]),
        .elem_shift (elem_shift),
        .addr       (blk_addr)
    );

    // byte n of the joined value is the most significant after shifting by n bytes
    assign joined  = {r_reg.src1, r_reg.src2} << {r_reg.align, 3'h0};
    assign extract = joined[127:64];

    assign addr_phase = hready && hsel && htrans[1];

    always_comb
    begin
        r_next           = r_reg;
        r_next.exec_pend = 1'b0;
        if (hready)
        begin
            r_next.sel_q  = hsel && htrans[1];
            r_next.addr_q = haddr[7:0];
            r_next.wr_q   = hwrite;
        end
        // data phase of a write
        if (r_reg.sel_q && r_reg.wr_q)
        begin
            case (r_reg.addr_q)
                iaau_pkg::OFF_INSN:    r_next.insn        = hwdata;
                iaau_pkg::OFF_SRC1_LO: r_next.src1[31:0]  = hwdata;
                iaau_pkg::OFF_SRC1_HI: r_next.src1[63:32] = hwdata;
                iaau_pkg::OFF_SRC2_LO: r_next.src2[31:0]  = hwdata;
                iaau_pkg::OFF_SRC2_HI: r_next.src2[63:32] = hwdata;
                iaau_pkg::OFF_FLAGS:   r_next.cc_flags    = hwdata[7:0];
                iaau_pkg::OFF_GSR:     r_next.align       = hwdata[2:0];
                iaau_pkg::OFF_CTRL:
                begin
                    if (hwdata[iaau_pkg::CTRL_GO])
                    begin
                        r_next.exec_pend = 1'b1;
                        r_next.done      = 1'b0;
                    end
                end
                default: r_next.exec_pend = 1'b0;
            endcase
        end
        // execution overrides a software write in the same cycle
        if (r_reg.exec_pend)
        begin
            r_next.done   = 1'b1;
            r_next.bad_op = (kind == iaau_pkg::K_NONE);
            case (kind)
                iaau_pkg::K_ADD:
                begin
                    r_next.result = add_sum;
                    if (is_cc)
                        r_next.cc_flags = {xcc, icc};
                end
                iaau_pkg::K_ALIGN:
                begin
                    r_next.result = {add_sum[63:3], 3'h0};
                    r_next.align  = add_sum[2:0];
                end
                iaau_pkg::K_ALIGN_LE:
                begin
                    r_next.result = {add_sum[63:3], 3'h0};
                    r_next.align  = 3'h0 - add_sum[2:0];
                end
                iaau_pkg::K_EXTRACT: r_next.result = extract;
                iaau_pkg::K_ARRAY:   r_next.result = blk_addr;
                default:             r_next.result = r_reg.result;
            endcase
        end
        // read data taken from the post-write view so a read right after a write sees it
        if (addr_phase && !hwrite)
        begin
            case (haddr[7:0])
                iaau_pkg::OFF_INSN:    r_next.rdata = r_next.insn;
                iaau_pkg::OFF_SRC1_LO: r_next.rdata = r_next.src1[31:0];
                iaau_pkg::OFF_SRC1_HI: r_next.rdata = r_next.src1[63:32];
                iaau_pkg::OFF_SRC2_LO: r_next.rdata = r_next.src2[31:0];
                iaau_pkg::OFF_SRC2_HI: r_next.rdata = r_next.src2[63:32];
                iaau_pkg::OFF_RES_LO:  r_next.rdata = r_next.result[31:0];
                iaau_pkg::OFF_RES_HI:  r_next.rdata = r_next.result[63:32];
                iaau_pkg::OFF_FLAGS:   r_next.rdata = {24'h0, r_next.cc_flags};
                iaau_pkg::OFF_GSR:     r_next.rdata = {29'h0, r_next.align};
                iaau_pkg::OFF_CTRL:
                    r_next.rdata = {19'h0, r_next.insn[iaau_pkg::RD_HI:iaau_pkg::RD_LO],
                                    5'h0, r_next.bad_op, r_next.done, r_next.exec_pend};
                default:               r_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_reg.insn      <= iaau_pkg::RST_INSN;
            r_reg.src1      <= iaau_pkg::RST_DATA;
            r_reg.src2      <= iaau_pkg::RST_DATA;
            r_reg.result    <= iaau_pkg::RST_DATA;
            r_reg.cc_flags  <= iaau_pkg::RST_FLAGS;
            r_reg.align     <= iaau_pkg::RST_ALIGN;
            r_reg.exec_pend <= 1'b0;
            r_reg.done      <= 1'b0;
            r_reg.bad_op    <= 1'b0;
            r_reg.addr_q    <= 8'h00;
            r_reg.wr_q      <= 1'b0;
            r_reg.sel_q     <= 1'b0;
            r_reg.rdata     <= 32'h0000_0000;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = r_reg.rdata;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_exec_add_reg;
        r_reg.exec_pend && kind == iaau_pkg::K_ADD && !f_imm_sel;
    endsequence

    sequence s_exec_add_imm;
        r_reg.exec_pend && kind == iaau_pkg::K_ADD && f_imm_sel;
    endsequence

    a_add_reg_sum: assert property (s_exec_add_reg |=> r_reg.result ==
        $past(r_reg.src1 + r_reg.src2 + {63'h0, is_carry & r_reg.cc_flags[0]}))
        else $error("register add result wrong");

    a_add_imm_sum: assert property (s_exec_add_imm |=> r_reg.result ==
        $past(r_reg.src1 + imm_ext + {63'h0, is_carry & r_reg.cc_flags[0]}))
        else $error("immediate add result wrong");

    a_carry_from_icc: assert property (s_exec_add_reg ##0 is_carry ##0
        (r_reg.cc_flags[4] != r_reg.cc_flags[0]) |=> r_reg.result ==
        $past(r_reg.src1 + r_reg.src2 + {63'h0, r_reg.cc_flags[0]}))
        else $error("carry taken from wrong flag set");

    a_cc_kept_plain: assert property (r_reg.exec_pend && kind == iaau_pkg::K_ADD
        && !is_cc |=> $stable(r_reg.cc_flags))
        else $error("plain add changed condition codes");

    a_cc_carry_out: assert property (r_reg.exec_pend && kind == iaau_pkg::K_ADD
        && is_cc |=> r_reg.cc_flags[4] == ({1'b0, $past(r_reg.src1)}
        + {1'b0, $past(f_imm_sel ? imm_ext : r_reg.src2)}
        + {64'h0, $past(is_carry & r_reg.cc_flags[0])} > 65'h0_FFFF_FFFF_FFFF_FFFF))
        else $error("64-bit carry flag wrong");

    a_align_addr: assert property (r_reg.exec_pend && kind == iaau_pkg::K_ALIGN
        |=> r_reg.result[2:0] == 3'h0 && r_reg.align == $past(r_reg.src1[2:0]
        + r_reg.src2[2:0]))
        else $error("align address result or field wrong");

    a_align_le: assert property (r_reg.exec_pend && kind == iaau_pkg::K_ALIGN_LE
        |=> r_reg.align + $past(r_reg.src1[2:0] + r_reg.src2[2:0]) == 3'h0)
        else $error("little-endian alignment field wrong");

    a_extract_zero: assert property (r_reg.exec_pend && kind == iaau_pkg::K_EXTRACT
        && r_reg.align == 3'h0 |=> r_reg.result == $past(r_reg.src1))
        else $error("extract at offset zero wrong");

    a_extract_last: assert property (r_reg.exec_pend && kind == iaau_pkg::K_EXTRACT
        && r_reg.align == 3'h7 |=> r_reg.result[55:0] == $past(r_reg.src2[63:8]))
        else $error("extract at offset seven wrong");

    a_array_zero_top: assert property (r_reg.exec_pend && kind == iaau_pkg::K_ARRAY
        && r_reg.src2[2:0] == 3'h0 |=> r_reg.result[63:23] == 41'h0)
        else $error("blocked address high bits not zero");

    a_array_word_low: assert property (r_reg.exec_pend && f_opf == iaau_pkg::OPF_BLK_WORD
        && kind == iaau_pkg::K_ARRAY |=> r_reg.result[1:0] == 2'h0
        && r_reg.result[3:2] == $past(r_reg.src1[12:11]))
        else $error("word blocked address not shifted by two");

    a_done_after_go: assert property (r_reg.exec_pend |=> r_reg.done && !r_reg.exec_pend)
        else $error("done flag not set after execute");
endmodule : iaau_core
`default_nettype wire

// [hw/iaau_pkg.sv]
package iaau_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_INSN    = 8'h00;
    localparam logic [7:0] OFF_SRC1_LO = 8'h04;
    localparam logic [7:0] OFF_SRC1_HI = 8'h08;
    localparam logic [7:0] OFF_SRC2_LO = 8'h0C;
    localparam logic [7:0] OFF_SRC2_HI = 8'h10;
    localparam logic [7:0] OFF_CTRL    = 8'h14;
    localparam logic [7:0] OFF_RES_LO  = 8'h18;
    localparam logic [7:0] OFF_RES_HI  = 8'h1C;
    localparam logic [7:0] OFF_FLAGS   = 8'h20;
    localparam logic [7:0] OFF_GSR     = 8'h24;

    // reset values
    localparam logic [31:0] RST_INSN  = 32'h0000_0000;
    localparam logic [63:0] RST_DATA  = 64'h0000_0000_0000_0000;
    localparam logic [7:0]  RST_FLAGS = 8'h00;
    localparam logic [2:0]  RST_ALIGN = 3'h0;

    // instruction word fields
    localparam int OP_HI   = 31;
    localparam int OP_LO   = 30;
    localparam int RD_HI   = 29;
    localparam int RD_LO   = 25;
    localparam int OPER_HI = 24;
    localparam int OPER_LO = 19;
    localparam int SRCA_HI = 18;
    localparam int SRCA_LO = 14;
    localparam int IMM_SEL = 13;
    localparam int OPF_HI  = 13;
    localparam int OPF_LO  = 5;
    localparam int SRCB_HI = 4;
    localparam int SRCB_LO = 0;
    localparam int SIMM_HI = 12;

    // encodings
    localparam logic [1:0] OP_ARITH      = 2'h2;
    localparam logic [5:0] OPER_ADD      = 6'h00;
    localparam logic [5:0] OPER_ADDCC    = 6'h10;
    localparam logic [5:0] OPER_ADDC     = 6'h08;
    localparam logic [5:0] OPER_ADDCCC   = 6'h18;
    localparam logic [5:0] OPER_GRAPHICS = 6'h36;
    localparam logic [8:0] OPF_ALIGN     = 9'h018;
    localparam logic [8:0] OPF_ALIGN_LE  = 9'h01A;
    localparam logic [8:0] OPF_EXTRACT   = 9'h048;
    localparam logic [8:0] OPF_BLK_BYTE  = 9'h010;
    localparam logic [8:0] OPF_BLK_HALF  = 9'h012;
    localparam logic [8:0] OPF_BLK_WORD  = 9'h014;

    // control / status bits
    localparam int CTRL_GO    = 0;
    localparam int STAT_PEND  = 0;
    localparam int STAT_DONE  = 1;
    localparam int STAT_BAD   = 2;
    localparam int STAT_RD_LO = 8;

    // condition-code register: xcc in 7:4, icc in 3:0, each n z v c
    localparam int CC_C       = 0;
    localparam int XCC_LO     = 4;

    // fixed-point 3D address integer fields
    localparam int ZI_HI = 63;
    localparam int ZI_LO = 55;
    localparam int YI_HI = 43;
    localparam int YI_LO = 33;
    localparam int XI_HI = 21;
    localparam int XI_LO = 11;
    localparam int BLK_UPPER_LO = 18;

    typedef enum {K_NONE, K_ADD, K_ALIGN, K_ALIGN_LE, K_EXTRACT, K_ARRAY} iaau_kind_t;

    typedef struct packed {
        logic [31:0] insn;
        logic [63:0] src1;
        logic [63:0] src2;
        logic [63:0] result;
        logic [7:0]  cc_flags;
        logic [2:0]  align;
        logic        exec_pend;
        logic        done;
        logic        bad_op;
        logic [7:0]  addr_q;
        logic        wr_q;
        logic        sel_q;
        logic [31:0] rdata;
    } iaau_state_t;

endpackage : iaau_pkg

// [hw/iaau_adder.sv]
`timescale 1ns/1ps
`default_nettype none
module iaau_adder
(
    input  wire logic [63:0] a,
    input  wire logic [63:0] b,
    input  wire logic        cin,
    output logic      [63:0] sum,
    output logic      [3:0]  icc,
    output logic      [3:0]  xcc
);
    logic [32:0] lo;
    logic [32:0] hi;

    // split at bit 31 to get the 32-bit carry as well as the 64-bit one
    assign lo  = {1'b0, a[31:0]} + {1'b0, b[31:0]} + {32'h0000_0000, cin};
    assign hi  = {1'b0, a[63:32]} + {1'b0, b[63:32]} + {32'h0000_0000, lo[32]};
    assign sum = {hi[31:0], lo[31:0]};

    // overflow: operands agree in sign and the sum does not
    assign icc = {sum[31], sum[31:0] == 32'h0000_0000,
                  (a[31] == b[31]) && (sum[31] != a[31]), lo[32]};
    assign xcc = {sum[63], sum == 64'h0000_0000_0000_0000,
                  (a[63] == b[63]) && (sum[63] != a[63]), hi[32]};
endmodule : iaau_adder
`default_nettype wire

// [hw/iaau_blocked.sv]
`timescale 1ns/1ps
`default_nettype none
module iaau_blocked
(
    input  wire logic [63:0] src,
    input  wire logic [2:0]  size,
    input  wire logic [1:0]  elem_shift,
    output logic      [63:0] addr
);
    logic [8:0]  z_int;
    logic [10:0] y_int;
    logic [10:0] x_int;
    logic [5:0]  mask6;
    logic [4:0]  x_up;
    logic [4:0]  y_up;
    logic [63:0] base;
    logic [63:0] upper;

    // only the integer parts take part
    assign z_int = src[iaau_pkg::ZI_HI:iaau_pkg::ZI_LO];
    assign y_int = src[iaau_pkg::YI_HI:iaau_pkg::YI_LO];
    assign x_int = src[iaau_pkg::XI_HI:iaau_pkg::XI_LO];

    // x and y bits beyond the selected dimension are dropped
    assign mask6 = (6'h01 << size) - 6'h01;
    assign x_up  = x_int[10:6] & mask6[4:0];
    assign y_up  = y_int[10:6] & mask6[4:0];

    assign base  = {46'h0, z_int[5:2], y_int[5:2], x_int[5:2],
                    z_int[1:0], y_int[1:0], x_int[1:0]};
    // everything above the upper z field stays zero
    assign upper = 64'(x_up) | (64'(y_up) << size)
                 | (64'(z_int[8:6]) << {size, 1'b0});
    assign addr  = (base | (upper << iaau_pkg::BLK_UPPER_LO)) << elem_shift;
endmodule : iaau_blocked
`default_nettype wire

// [verif/iaau_host.sv]
`timescale 1ns/1ps
`default_nettype none
module iaau_host
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // one whole-word single transfer; released select, transfer and address lines do not keep old values
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~haddr;
        hwdata <= w ? d : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    endtask : xfer
endmodule : iaau_host
`default_nettype wire

// [verif/tb_integer_add_align_array_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp); \
        end \
    end
module tb_integer_add_align_array_unit;
    localparam logic [7:0] ZOFF [7] = '{8'h00, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h40};
    localparam logic [5:0] ADDS [4] = '{6'h00, 6'h10, 6'h08, 6'h18};
    localparam logic [8:0] BLKS [3] = '{9'h010, 9'h012, 9'h014};
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] lfsr;
    int          err_total;
    int          cmp_count;

    iaau_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    iaau_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], ^(lfsr & 32'h8020_0003)};
        return lfsr;
    endfunction : rnd

    function automatic logic [63:0] blk(input logic [63:0] s, input int n, input int e);
        logic [63:0] r;
        logic [63:0] m;
        m = (64'h1 << n) - 64'h1;
        r = {46'h0, s[60:57], s[38:35], s[16:13], s[56:55], s[34:33], s[12:11]};
        r = r | (({59'h0, s[21:17]} & m) << 18) | (({59'h0, s[43:39]} & m) << (18 + n));
        r = r | ({61'h0, s[63:61]} << (18 + 2 * n));
        return r << e;
    endfunction : blk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host_u.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        host_u.xfer(1'b0, a, 32'h0000_0000, q);
        `CHK(hresp, 1'b0)
        `CHK(hreadyout, 1'b1)
    endtask : rd

    task automatic run(input logic [31:0] insn, input logic [63:0] s1, input logic [63:0] s2,
                       input logic bad, output logic [63:0] res);
        logic [31:0] st;
        int          n;
        wr(8'h00, insn);
        wr(8'h04, s1[31:0]);
        wr(8'h08, s1[63:32]);
        wr(8'h0C, s2[31:0]);
        wr(8'h10, s2[63:32]);
        wr(8'h14, 32'h0000_0001);
        n = 0;
        do
        begin
            rd(8'h14, st);
            n++;
        end
        while (st[iaau_pkg::STAT_PEND] !== 1'b0 && n < 20);
        `CHK(st[iaau_pkg::STAT_PEND], 1'b0)
        `CHK(st[iaau_pkg::STAT_DONE], 1'b1)
        `CHK(st[iaau_pkg::STAT_BAD], bad)
        `CHK(st[12:8], insn[29:25])
        rd(8'h18, res[31:0]);
        rd(8'h1C, res[63:32]);
    endtask : run

    task automatic conclude();
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        #1_000_000;
        err_total++;
        conclude();
    end

    initial
    begin
        logic [63:0]  s1;
        logic [63:0]  s2;
        logic [63:0]  b;
        logic [63:0]  r;
        logic [127:0] w;
        logic [64:0]  s65;
        logic [32:0]  s33;
        logic [31:0]  q;
        logic [31:0]  insn;
        logic [7:0]   cc;
        logic [7:0]   ecc;
        logic [5:0]   oper;
        logic         ci;
        int           k;
        int           e;
        lfsr = 32'h0000_FC7A;
        err_total = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        wr(8'h40, 32'hFFFF_FFFF);
        foreach (ZOFF[i])
        begin
            rd(ZOFF[i], q);
            `CHK(q, 32'h0000_0000)
        end
        // last four cases overflow the low word and the whole word
        for (k = 0; k < 12; k++)
        begin
            oper = ADDS[k % 4];
            s1 = (k < 8) ? {rnd(), rnd()} : 64'h7FFF_FFFF_7FFF_FFFF;
            s2 = (k < 8) ? {rnd(), rnd()} : 64'h0000_0001_0000_0001;
            q = rnd();
            insn = {2'h2, 5'h03, oper, 5'h01, k[2], q[12:0]};
            cc = k[0] ? 8'h10 : 8'h01;
            wr(8'h20, {24'h00_0000, cc});
            b = insn[13] ? {{51{insn[12]}}, insn[12:0]} : s2;
            ci = oper[3] & cc[0];
            s65 = {1'b0, s1} + {1'b0, b} + {64'h0, ci};
            s33 = {1'b0, s1[31:0]} + {1'b0, b[31:0]} + {32'h0, ci};
            ecc = {s65[63], ~|s65[63:0], s1[63] == b[63] && s65[63] != s1[63], s65[64],
                   s33[31], ~|s33[31:0], s1[31] == b[31] && s33[31] != s1[31], s33[32]};
            run(insn, s1, s2, 1'b0, r);
            `CHK(r, s65[63:0])
            rd(8'h20, q);
            `CHK(q[7:0], oper[4] ? ecc : cc)
        end
        for (k = 0; k < 4; k++)
        begin
            s1 = {rnd(), rnd()};
            s2 = {rnd(), rnd()};
            r = s1 + s2;
            insn = {2'h2, 5'h04, iaau_pkg::OPER_GRAPHICS, 5'h01,
                    k[0] ? iaau_pkg::OPF_ALIGN_LE : iaau_pkg::OPF_ALIGN, 5'h02};
            run(insn, s1, s2, 1'b0, b);
            `CHK(b, {r[63:3], 3'h0})
            rd(8'h24, q);
            `CHK(q[2:0], k[0] ? 3'h0 - r[2:0] : r[2:0])
        end
        for (k = 0; k < 8; k++)
        begin
            wr(8'h24, k[31:0]);
            s1 = {rnd(), rnd()};
            s2 = {rnd(), rnd()};
            w = {s1, s2} << (8 * k);
            insn = {2'h2, 5'h07, iaau_pkg::OPER_GRAPHICS, 5'h01, iaau_pkg::OPF_EXTRACT, 5'h02};
            run(insn, s1, s2, 1'b0, b);
            `CHK(b, w[127:64])
        end
        for (e = 0; e < 3; e++)
            for (k = 0; k < 6; k++)
            begin
                s1 = {rnd(), rnd()};
                run({2'h2, 5'h05, iaau_pkg::OPER_GRAPHICS, 5'h01, BLKS[e], 5'h02},
                    s1, 64'(k), 1'b0, r);
                `CHK(r, blk(s1, k, e))
            end
        // undecoded words leave the result alone
        for (k = 0; k < 2; k++)
        begin
            insn = k[0] ? {2'h2, 5'h06, iaau_pkg::OPER_GRAPHICS, 5'h01, 9'h000, 5'h02}
                        : {2'h0, 5'h06, 6'h00, 5'h01, 14'h0000};
            run(insn, {rnd(), rnd()}, {rnd(), rnd()}, 1'b1, b);
            `CHK(b, r)
        end
        conclude();
    end
endmodule : tb_integer_add_align_array_unit
`default_nettype wire
